// *** logic/flash_defs.svh ***
// Shared constants for the partition read-mode link and its host.
// Assumes inclusion by bare name from the package and both ends.
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

`define FL_AW          22
`define FL_DW          16
`define FL_PBITS       2
`define FL_NPART       4

`define CMD_READ_ARRAY 8'hff
`define CMD_READ_ID    8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_READ_SR    8'h70
`define CMD_CLEAR_SR   8'h50
`define CMD_ERASE      8'h20
`define CMD_PROG_A     8'h40
`define CMD_PROG_B     8'h10
`define CMD_EFP        8'h30
`define CMD_LOCK_SETUP 8'h60
`define CMD_PROT_PROG  8'hc0
`define CMD_SUSPEND    8'hb0
`define CMD_CONFIRM    8'hd0
`define CMD_LOCK       8'h01
`define CMD_LOCKDOWN   8'h2f
`define CMD_SET_CFG    8'h03

`define ID_MFR         8'h00
`define ID_DEV         8'h01
`define ID_LOCK        8'h02
`define ID_CFG         8'h05
`define ID_PLOCK       8'h80
`define ID_PREG_LO     8'h81
`define ID_PREG_HI     8'h88

`define INVALID_DATA   16'hffff

`define HOST_CTRL      8'h00
`define HOST_ADDR      8'h04
`define HOST_WDATA     8'h08
`define HOST_RDATA     8'h0c
`define HOST_STATUS    8'h10
`define CTRL_WR_BIT    0
`define CTRL_RD_BIT    1

`endif

// *** logic/flash_pkg.sv ***
// Types shared by both ends of the partition read-mode link.
// Assumes flash_defs.svh is on the include path.
`include "flash_defs.svh"

package flash_pkg;
	typedef logic [`FL_AW-1:0] addr_t;
	typedef logic [`FL_DW-1:0] data_t;
	typedef logic [`FL_PBITS-1:0] part_t;

	// Gray order: array, status, identifier, query
	typedef enum logic [1:0] {
		MODE_ARRAY  = 2'h0,
		MODE_STATUS = 2'h1,
		MODE_IDENT  = 2'h3,
		MODE_QUERY  = 2'h2
	} mode_t;
endpackage

// *** logic/flash_link_if.sv ***
// Bus between the command host and the partitioned flash command decoder.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps

interface flash_link_if (
	input wire logic clock
);
	import flash_pkg::*;
	addr_t addr;
	data_t wdata;
	logic  wr;
	logic  rd;
	data_t rdata;
	logic  rvalid;

	modport device_end (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
	modport host_end (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface // flash_link_if

// *** logic/flash_cmd_dev.sv ***
// Command decoder with per-partition read modes for a multi-partition flash.
// Assumes array, lock, query and id data are valid in the same cycle as look_addr,
// and a write state machine outside runs the program, erase and lock work.
//
// Summary of operation
// [R01] Reads between setup and confirm keep sequence.
// [R02] Setup write puts partition in status mode.
// [R03] Other array-mode partitions return array data.
// [R04] Host inserts no other write mid-sequence; host here only reports seq_open in HOST_STATUS, blocks a write only while a read is busy.
// [R05] Interrupting write aborts sequence, flags error.
// [R06] FFh selects array-read mode for partition.
// [R07] Reset leaves every partition in array mode.
// [R08] Array mode persists without reissuing command.
// [R09] Array read of busy partition gives invalid.
// [R10] Array command works while machine is suspended.
// [R11] Array command ignores programming supply level.
// [R12] 90h selects identifier mode for partition.
// [R13] Identifier command works during background operation.
// [R14] Offsets 00h, 01h, 05h: maker, device, config.
// [R15] Block base plus 02h gives lock bits.
// [R16] 80h protection lock; 81h-88h protection words.
// [R17] Query mode returns database field at offset.
// [R18] Query command works during background operation.
// [R19] Status byte low, upper byte zeros.
// [R20] Sequence error sets ready, erase, program bits.
// [R21] Program, erase, lock leave partition in status.
// [R22] Each partition holds its own read mode.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "flash_defs.svh"

module flash_cmd_dev
	import flash_pkg::*;
#(
	// Arbitrary identity values
	parameter logic [15:0] MFR_CODE = 16'h00a5,
	parameter logic [15:0] DEV_CODE = 16'h5a01
) (
	input  wire logic                    clock,
	input  wire logic                    rstn,
	flash_link_if.device_end             link,
	output flash_pkg::addr_t             look_addr,
	input  wire flash_pkg::data_t        array_data,
	input  wire logic [1:0]              lock_state,
	input  wire logic [7:0]              query_data,
	input  wire flash_pkg::data_t        config_data,
	input  wire flash_pkg::data_t        prot_lock,
	input  wire logic [127:0]            prot_reg,
	input  wire logic [`FL_NPART-1:0]    part_busy,
	input  wire logic                    erase_susp,
	input  wire logic                    prog_susp,
	input  wire logic                    vpp_low,
	output logic                         op_start,
	output logic [7:0]                   op_code,
	output logic [7:0]                   op_confirm,
	output flash_pkg::addr_t             op_addr,
	output flash_pkg::data_t             op_data
);
	import flash_pkg::*;

	typedef struct packed {
		mode_t [`FL_NPART-1:0] mode;
		logic [`FL_NPART-1:0]  err_e;
		logic [`FL_NPART-1:0]  err_p;
		logic                  pend;
		logic [7:0]            pend_code;
		addr_t                 pend_addr;
		logic                  rstage;
		addr_t                 look_addr;
		data_t                 rdata;
		logic                  rvalid;
		logic                  op_start;
		logic [7:0]            op_code;
		logic [7:0]            op_confirm;
		addr_t                 op_addr;
		data_t                 op_data;
	} dev_state_t;

	dev_state_t state_reg;
	dev_state_t state_next;

	function automatic part_t part_of(input addr_t a);
		part_of = a[`FL_AW-1 -: `FL_PBITS];
	endfunction

	function automatic logic confirm_ok(input logic [7:0] setup, input logic [7:0] c);
		case (setup)
			`CMD_ERASE, `CMD_EFP: confirm_ok = (c == `CMD_CONFIRM);
			`CMD_LOCK_SETUP: confirm_ok = (c == `CMD_LOCK) || (c == `CMD_CONFIRM) ||
				(c == `CMD_LOCKDOWN) || (c == `CMD_SET_CFG);
			default: confirm_ok = 1'b1;
		endcase
	endfunction

	part_t      wpart;
	part_t      rpart;
	logic [7:0] wcode;
	logic [7:0] offs;
	logic [7:0] sr_byte;
	logic       busy_eff;
	logic [2:0] pidx;

	always_comb begin
		state_next          = state_reg;
		state_next.op_start = 1'b0;
		state_next.rvalid   = 1'b0;
		wpart               = part_of(link.addr);
		wcode               = link.wdata[7:0];
		rpart               = part_of(state_reg.look_addr);
		offs                = state_reg.look_addr[7:0];
		pidx                = 3'(offs - `ID_PREG_LO);
		// Suspended machine counts as idle for array reads
		busy_eff            = part_busy[rpart] & ~(erase_susp | prog_susp);
		// [R20] error shows ready bit
		sr_byte = {~(|part_busy) | (state_reg.err_e[rpart] & state_reg.err_p[rpart]),
			erase_susp, state_reg.err_e[rpart], state_reg.err_p[rpart],
			vpp_low, prog_susp, 1'b0, ~part_busy[rpart]};

		// [R01] reads never touch pending
		if (link.rd) begin
			state_next.look_addr = link.addr;
			state_next.rstage    = 1'b1;
		end
		if (state_reg.rstage) begin
			state_next.rstage = 1'b0;
			state_next.rvalid = 1'b1;
			// [R22] mode of read partition
			case (state_reg.mode[rpart])
				MODE_STATUS: begin
					// [R19] upper byte zero
					state_next.rdata = {8'h00, sr_byte};
				end
				MODE_IDENT: begin
					// [R14] identifier offsets
					if (offs == `ID_MFR)
						state_next.rdata = MFR_CODE;
					else if (offs == `ID_DEV)
						state_next.rdata = DEV_CODE;
					// [R15] block lock bits
					else if (offs == `ID_LOCK)
						state_next.rdata = {14'h0000, lock_state};
					else if (offs == `ID_CFG)
						state_next.rdata = config_data;
					// [R16] protection lock and words
					else if (offs == `ID_PLOCK)
						state_next.rdata = prot_lock;
					else if (offs >= `ID_PREG_LO && offs <= `ID_PREG_HI)
						state_next.rdata = prot_reg[pidx*16 +: 16];
					else
						state_next.rdata = 16'h0000;
				end
				MODE_QUERY: begin
					// [R17] database field
					state_next.rdata = {8'h00, query_data};
				end
				default: begin
					// [R09] busy partition invalid
					if (busy_eff)
						state_next.rdata = `INVALID_DATA;
					// [R03] [R08] plain array data
					else
						state_next.rdata = array_data;
				end
			endcase
		end

		if (link.wr) begin
			if (state_reg.pend) begin
				state_next.pend = 1'b0;
				if (part_of(state_reg.pend_addr) == wpart &&
					confirm_ok(state_reg.pend_code, wcode)) begin
					state_next.op_start   = 1'b1;
					state_next.op_code    = state_reg.pend_code;
					state_next.op_confirm = wcode;
					state_next.op_addr    = link.addr;
					state_next.op_data    = link.wdata;
					// [R21] status after sequence
					state_next.mode[wpart] = MODE_STATUS;
				end else begin
					// [R05] abandon and flag
					state_next.err_e[part_of(state_reg.pend_addr)] = 1'b1;
					state_next.err_p[part_of(state_reg.pend_addr)] = 1'b1;
					state_next.mode[part_of(state_reg.pend_addr)]  = MODE_STATUS;
				end
			end else begin
				case (wcode)
					// [R06] [R10] [R11] array mode
					`CMD_READ_ARRAY: state_next.mode[wpart] = MODE_ARRAY;
					// [R12] [R13] identifier mode
					`CMD_READ_ID: state_next.mode[wpart] = MODE_IDENT;
					// [R18] query mode
					`CMD_READ_QUERY: state_next.mode[wpart] = MODE_QUERY;
					`CMD_READ_SR: state_next.mode[wpart] = MODE_STATUS;
					`CMD_CLEAR_SR: begin
						state_next.err_e = '0;
						state_next.err_p = '0;
					end
					`CMD_SUSPEND, `CMD_CONFIRM: begin
						state_next.op_start   = 1'b1;
						state_next.op_code    = wcode;
						state_next.op_confirm = 8'h00;
						state_next.op_addr    = link.addr;
						state_next.op_data    = link.wdata;
						state_next.mode[wpart] = MODE_STATUS;
					end
					`CMD_ERASE, `CMD_PROG_A, `CMD_PROG_B, `CMD_EFP,
					`CMD_LOCK_SETUP, `CMD_PROT_PROG: begin
						state_next.pend      = 1'b1;
						state_next.pend_code = wcode;
						state_next.pend_addr = link.addr;
						// [R02] setup selects status
						state_next.mode[wpart] = MODE_STATUS;
					end
					default: begin
						state_next.pend = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_reg <= '0;
			// [R07] all partitions array mode
			for (int i = 0; i < `FL_NPART; i++) begin
				state_reg.mode[i] <= MODE_ARRAY;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.rdata  = state_reg.rdata;
	assign link.rvalid = state_reg.rvalid;
	assign look_addr   = state_reg.look_addr;
	assign op_start    = state_reg.op_start;
	assign op_code     = state_reg.op_code;
	assign op_confirm  = state_reg.op_confirm;
	assign op_addr     = state_reg.op_addr;
	assign op_data     = state_reg.op_data;
endmodule // flash_cmd_dev

// *** logic/flash_cmd_host.sv ***
// Host end: APB registers launch single writes and reads on the flash link.
// Assumes APB runs on the same clock; one link transfer outstanding at a time.
`timescale 1ns/1ps
`include "flash_defs.svh"

module flash_cmd_host
	import flash_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	flash_link_if.host_end   link
);
	import flash_pkg::*;

	typedef struct packed {
		addr_t       addr;
		data_t       wdata;
		data_t       rdata;
		logic        wr;
		logic        rd;
		logic        busy;
		logic        seq_open;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} host_state_t;

	host_state_t state_reg;
	host_state_t state_next;
	logic        setup;
	logic        access;
	logic [7:0]  code;

	function automatic logic is_setup(input logic [7:0] c);
		is_setup = (c == `CMD_ERASE) || (c == `CMD_PROG_A) || (c == `CMD_PROG_B) ||
			(c == `CMD_EFP) || (c == `CMD_LOCK_SETUP) || (c == `CMD_PROT_PROG);
	endfunction

	always_comb begin
		state_next         = state_reg;
		state_next.wr      = 1'b0;
		state_next.rd      = 1'b0;
		setup              = psel & ~penable;
		access             = psel & penable & state_reg.pready;
		code               = state_reg.wdata[7:0];
		state_next.pready  = setup;
		state_next.pslverr = 1'b0;
		if (setup) begin
			case (paddr)
				`HOST_CTRL, `HOST_ADDR, `HOST_WDATA: state_next.prdata = 32'h0000_0000;
				`HOST_RDATA: state_next.prdata = {16'h0000, state_reg.rdata};
				`HOST_STATUS: state_next.prdata = {30'h0, state_reg.seq_open, state_reg.busy};
				default: begin
					state_next.prdata  = 32'h0000_0000;
					state_next.pslverr = 1'b1;
				end
			endcase
		end
		if (access && pwrite) begin
			case (paddr)
				// [R06] [R12] [R17] base plus offset
				`HOST_ADDR: state_next.addr = pwdata[`FL_AW-1:0];
				`HOST_WDATA: state_next.wdata = pwdata[`FL_DW-1:0];
				`HOST_CTRL: begin
					if (!state_reg.busy && pwdata[`CTRL_WR_BIT]) begin
						state_next.wr = 1'b1;
						// [R04] confirm follows setup
						state_next.seq_open = state_reg.seq_open ? 1'b0 : is_setup(code);
					end else if (!state_reg.busy && pwdata[`CTRL_RD_BIT]) begin
						// [R01] read keeps sequence
						state_next.rd   = 1'b1;
						state_next.busy = 1'b1;
					end
				end
				default: begin
					state_next.pslverr = 1'b0;
				end
			endcase
		end
		if (link.rvalid && state_reg.busy) begin
			state_next.rdata = link.rdata;
			state_next.busy  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign prdata     = state_reg.prdata;
	assign pready     = state_reg.pready;
	assign pslverr    = state_reg.pslverr;
	assign link.addr  = state_reg.addr;
	assign link.wdata = state_reg.wdata;
	assign link.wr    = state_reg.wr;
	assign link.rd    = state_reg.rd;
endmodule // flash_cmd_host

// *** bench/link_mode_chk.sv ***
// Checker for the link between the command host and the partition decoder.
// Assumes it sits beside the link interface, taking its signals as inputs.
`timescale 1ns/1ps

module link_mode_chk
	import flash_pkg::*;
#(
	parameter logic [15:0] MFR_CODE = 16'h00a5,
	parameter logic [15:0] DEV_CODE = 16'h5a01
) (
	input wire logic             clock,
	input wire logic             rstn,
	input wire flash_pkg::addr_t addr,
	input wire flash_pkg::data_t wdata,
	input wire logic             wr,
	input wire logic             rd,
	input wire flash_pkg::data_t rdata,
	input wire logic             rvalid
);
	import flash_pkg::*;
	logic [7:0] lc_reg, pc_reg, o1_reg, o2_reg;
	part_t      lp_reg, pp_reg, p1_reg, p2_reg;
	logic       same;

	// Last two write codes, address of the read in flight
	always_ff @(posedge clock) begin
		if (!rstn) begin
			{lc_reg, pc_reg, o1_reg, o2_reg} <= '0;
			{lp_reg, pp_reg, p1_reg, p2_reg} <= '0;
		end else begin
			if (wr) begin
				{lc_reg, pc_reg} <= {wdata[7:0], lc_reg};
				{lp_reg, pp_reg} <= {addr[21:20], lp_reg};
			end
			{p1_reg, p2_reg} <= {addr[21:20], p1_reg};
			{o1_reg, o2_reg} <= {addr[7:0], o1_reg};
		end
	end
	assign same = (lp_reg == p2_reg);

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	read_answer_a: assert property (rd |-> ##2 rvalid)
		else $error("read not answered");
	answer_cause_a: assert property (rvalid |-> $past(rd, 2))
		else $error("answer without read");
	answer_pulse_a: assert property (rvalid |=> !rvalid)
		else $error("answer longer than one cycle");
	status_byte_a: assert property (rvalid && same && (lc_reg == 8'h70 || lc_reg == 8'h20)
		|-> rdata[15:8] == 8'h00)
		else $error("status upper byte not zero");
	seq_error_a: assert property (rvalid && pc_reg == 8'h20 && lc_reg != 8'hd0 &&
		lc_reg != 8'h50 && pp_reg == p2_reg |-> rdata[7] && rdata[5] && rdata[4])
		else $error("sequence error bits missing");
	maker_code_a: assert property (rvalid && same && lc_reg == 8'h90 && o2_reg == 8'h00
		|-> rdata == MFR_CODE)
		else $error("maker code wrong");
	device_code_a: assert property (rvalid && same && lc_reg == 8'h90 && o2_reg == 8'h01
		|-> rdata == DEV_CODE)
		else $error("device code wrong");
	query_byte_a: assert property (rvalid && same && lc_reg == 8'h98
		|-> rdata[15:8] == 8'h00)
		else $error("query upper byte not zero");

	cover property (rvalid && same && lc_reg == 8'h90);
	cover property (rvalid && pc_reg == 8'h20 && lc_reg != 8'hd0);
	cover property (rvalid && same && lc_reg == 8'h20);
endmodule // link_mode_chk

// *** bench/test_flash_partition_read_mode_control.sv ***
// Testbench: APB host end and decoder end joined by the link interface.
// Assumes flash_defs.svh on the include path; memory side modelled here.
`timescale 1ns/1ps
`include "flash_defs.svh"

module test_flash_partition_read_mode_control;
	import flash_pkg::*;
	typedef struct packed {addr_t wa; logic [7:0] c; addr_t ra; data_t e;} row_t;
	// Arbitrary identity values
	localparam data_t mfr_v = 16'h00a5;
	localparam data_t dev_v = 16'h5a01;
	localparam data_t cfg_v = 16'h1357;
	localparam data_t plk_v = 16'hfffd;
	localparam logic [127:0] preg_v = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, op_start;
	logic [3:0]  part_busy = '0;
	logic        erase_susp = 1'b0;
	logic        prog_susp = 1'b0;
	logic        vpp_low = 1'b0;
	logic [7:0]  op_code, op_confirm;
	logic [15:0] op_seen = '0;
	addr_t       look_addr, op_addr;
	data_t       op_data, array_data, v;
	int          n_ops = 0, n_errors = 0, checks_done = 0;
	row_t        rows [11];

	function automatic data_t arr(input addr_t a);
		return a[15:0] ^ 16'h3c3c;
	endfunction
	assign array_data = arr(look_addr);

	flash_link_if link_if (.clock(clock));
	flash_cmd_dev #(.MFR_CODE(mfr_v), .DEV_CODE(dev_v)) flash_cmd_dev_inst (
		.clock(clock), .rstn(rstn), .link(link_if), .look_addr(look_addr),
		.array_data(array_data), .lock_state(look_addr[9:8]),
		.query_data(look_addr[7:0] ^ 8'ha5), .config_data(cfg_v), .prot_lock(plk_v),
		.prot_reg(preg_v), .part_busy(part_busy), .erase_susp(erase_susp),
		.prog_susp(prog_susp), .vpp_low(vpp_low), .op_start(op_start), .op_code(op_code),
		.op_confirm(op_confirm), .op_addr(op_addr), .op_data(op_data));
	flash_cmd_host flash_cmd_host_inst (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if));
	link_mode_chk #(.MFR_CODE(mfr_v), .DEV_CODE(dev_v)) chk_inst (
		.clock(clock), .rstn(rstn), .addr(link_if.addr), .wdata(link_if.wdata),
		.wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata), .rvalid(link_if.rvalid));

	initial forever #10 clock = ~clock;

	always @(posedge clock) if (op_start === 1'b1) begin
		op_seen <= {op_code, op_confirm};
		n_ops <= n_ops + 1;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One link write (w=1) or read; waits out the host busy flag
	task automatic lnk(input logic w, input addr_t a, input logic [7:0] c);
		apb(1'b1, `HOST_ADDR, {10'h0, a});
		if (w) apb(1'b1, `HOST_WDATA, {24'h0, c});
		apb(1'b1, `HOST_CTRL, w ? 32'h1 : 32'h2);
		r = 32'h1;
		for (int i = 0; i < 20 && r[0] !== 1'b0; i++) apb(1'b0, `HOST_STATUS, 0);
		if (r[0] !== 1'b0) n_errors++;
		apb(1'b0, `HOST_RDATA, 0);
		v = r[15:0];
	endtask

	task automatic complete_run();
		$display("Mismatches %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		rows = '{'{22'h100000, 8'h90, 22'h100000, mfr_v},
			'{22'h100000, 8'h90, 22'h100001, dev_v},
			'{22'h100000, 8'h90, 22'h100005, cfg_v},
			'{22'h100000, 8'h90, 22'h100302, 16'h0003},
			'{22'h100000, 8'h90, 22'h100080, plk_v},
			'{22'h100000, 8'h90, 22'h100081, preg_v[15:0]},
			'{22'h100000, 8'h90, 22'h100088, preg_v[127:112]},
			'{22'h200000, 8'h98, 22'h200011, {8'h00, 8'h11 ^ 8'ha5}},
			'{22'h200000, 8'hff, 22'h200456, arr(22'h200456)},
			'{22'h300000, 8'h70, 22'h300000, 16'h0081},
			'{22'h100000, 8'h90, 22'h000777, arr(22'h000777)}};
		foreach (rows[i]) begin
			lnk(1'b1, rows[i].wa, rows[i].c);
			lnk(1'b0, rows[i].ra, 0);
			chk("row read", v, rows[i].e);
		end
		lnk(1'b1, 22'h100000, 8'hff);
		lnk(1'b1, 22'h000040, 8'h20);
		lnk(1'b0, 22'h000040, 0);
		chk("setup status", v, 16'h0081);
		lnk(1'b0, 22'h100010, 0);
		chk("other array", v, arr(22'h100010));
		lnk(1'b1, 22'h000040, 8'hd0);
		chk("op codes", op_seen, 16'h20d0);
		chk("op addr", op_addr, 32'h0000_0040);
		chk("op data", op_data, 32'h0000_00d0);
		lnk(1'b0, 22'h000040, 0);
		chk("after erase", v, 16'h0081);
		lnk(1'b1, 22'h200000, 8'h20);
		lnk(1'b1, 22'h300000, 8'hff);
		lnk(1'b0, 22'h200000, 0);
		chk("seq error", v, 16'h00b1);
		chk("op count", n_ops, 1);
		part_busy <= 4'h1;
		lnk(1'b1, 22'h000000, 8'hff);
		lnk(1'b0, 22'h000200, 0);
		chk("busy array", v, 16'hffff);
		lnk(1'b1, 22'h000000, 8'h90);
		lnk(1'b0, 22'h000000, 0);
		chk("busy ident", v, mfr_v);
		lnk(1'b1, 22'h000000, 8'h98);
		lnk(1'b0, 22'h000031, 0);
		chk("busy query", v, {8'h00, 8'h31 ^ 8'ha5});
		erase_susp <= 1'b1;
		lnk(1'b1, 22'h000000, 8'hff);
		lnk(1'b0, 22'h000200, 0);
		chk("suspended array", v, arr(22'h000200));
		erase_susp <= 1'b0;
		prog_susp <= 1'b1;
		lnk(1'b1, 22'h000000, 8'h90);
		lnk(1'b1, 22'h000000, 8'hff);
		lnk(1'b0, 22'h000204, 0);
		chk("prog suspended array", v, arr(22'h000204));
		part_busy <= 4'h0;
		prog_susp <= 1'b0;
		vpp_low <= 1'b1;
		lnk(1'b1, 22'h100000, 8'h90);
		lnk(1'b1, 22'h100000, 8'hff);
		lnk(1'b0, 22'h100300, 0);
		chk("low supply array", v, arr(22'h100300));
		rstn <= 1'b0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			lnk(1'b0, {p[1:0], 20'h00abc}, 0);
			chk("reset array", v, arr({p[1:0], 20'h00abc}));
		end
		apb(1'b0, 8'h20, 0);
		chk("unmapped error", e, 1'b1);
		complete_run();
	end
endmodule // test_flash_partition_read_mode_control
